//--- hw/asm_phy_dev.sv
// device phy end: align/notify transmit scheduling and elastic receive
`timescale 1ns/1ns
module asm_phy_dev (
	input logic CLK_I,
	input logic SRST_I,
	input asm_pkg::asm_mode_e MODE_I,
	input logic [1:0] RATE_I,
	input logic ORIG_I,
	input logic BRIDGE_I,
	input logic NOTIFY_EN_I,
	input logic NOTIFY_ROT_I,
	input logic [31:0] TX_DAT_I,
	input logic TX_VALID_I,
	output logic TX_READY_O,
	output logic [31:0] RX_DAT_O,
	output logic RX_VALID_O,
	output logic RX_OVERRUN_O,
	output logic RX_UNDERRUN_O,
	asm_link_if.dev LINK
);
	import asm_pkg::*;

	// ==========================================================
	// slot timing from the internal clock
	logic [DIV_W-1:0] div_q, div_d;
	logic clk_q, tick;

	assign tick = (div_q == LINK_DIV_M1);
	assign div_d = tick ? '0 : div_q + 3'h1;

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			div_q <= '0;
			clk_q <= 1'b0;
		end else begin
			div_q <= div_d;
			clk_q <= (div_d >= LINK_HALF);
		end
	end

	// ==========================================================
	// transmit slot decision
	logic in_link, skw_due, brg_due, need, prim_ntf, pair_q, pair_d;
	logic need_org, need_brg, ntf_en;
	logic [7:0] skw_q, skw_d, brg_q, brg_d;
	logic [31:0] prim_dw;
	logic [32:0] tx_q;

	assign in_link = (MODE_I == MODE_LINK);
	assign skw_due = (skw_q >= skw_limit(RATE_I));
	assign brg_due = (brg_q >= BRG_RUN_MAX);
	assign need_org = skw_due | ~TX_VALID_I;
	assign need_brg = pair_q | brg_due | ~TX_VALID_I;
	// forwarding: fill only when nothing waits
	assign need = ~in_link | (BRIDGE_I ? need_brg :
		ORIG_I ? need_org : ~TX_VALID_I);
	assign TX_READY_O = tick & ~need;
	assign ntf_en = NOTIFY_EN_I & ~BRIDGE_I;
	assign skw_d = need ? CNT_RST :
		(skw_q == CNT_SAT) ? skw_q : skw_q + 8'h01;
	assign brg_d = need ? CNT_RST :
		(brg_q == CNT_SAT) ? brg_q : brg_q + 8'h01;
	assign pair_d = BRIDGE_I & in_link & need & ~pair_q;

	asm_prim_sel u_sel (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.mode_i(MODE_I),
		.notify_en_i(ntf_en),
		.notify_rot_i(NOTIFY_ROT_I),
		.slot_i(tick),
		.prim_i(need),
		.prim_o(prim_dw),
		.ntf_o(prim_ntf)
	);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			tx_q <= {1'b1, ALIGN_DW[0]};
			skw_q <= CNT_RST;
			brg_q <= CNT_RST;
			pair_q <= 1'b0;
		end else if (tick) begin
			tx_q <= need ? {1'b1, prim_dw} : {1'b0, TX_DAT_I};
			skw_q <= skw_d;
			brg_q <= brg_d;
			pair_q <= pair_d;
		end
	end

	assign LINK.dev_clk = clk_q;
	assign LINK.dev_k = tx_q[32];
	assign LINK.dev_dw = tx_q[31:0];

	// ==========================================================
	// receive sampling: three flops, edge once stages 2 and 3 agree
	logic [33:0] s1_q, s2_q, s3_q;
	logic lvl_q, agree, rx_edge, rx_prim;

	assign agree = (s2_q == s3_q);
	assign rx_edge = agree & s3_q[33] & ~lvl_q;
	assign rx_prim = prim_match(s3_q[32], s3_q[31:0]);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= {LINK.ptr_clk, LINK.ptr_k, LINK.ptr_dw};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// link clock level, moved only once stages 2 and 3 agree
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= agree ? s3_q[33] : lvl_q;
		end
	end

	// ==========================================================
	// elasticity buffer
	logic [32:0] mem [EB_DEPTH];
	logic [EB_AW-1:0] wr_q, rd_q;
	logic [2:0] cnt_q, cnt_d;
	logic empty, full, room, push, pop;
	logic [32:0] rd_w;
	logic [31:0] rxd_q;
	logic rxv_q, ovr_q, und_q;

	assign empty = (cnt_q == 3'h0);
	assign full = (cnt_q == EB_DEPTH);
	assign pop = tick & ~empty;
	assign room = ~full | pop;
	// primitives are simply lost when there is no room
	assign push = rx_edge & room;
	assign rd_w = empty ? {1'b1, ALIGN_DW[0]} : mem[rd_q];
	assign cnt_d = (push & ~pop) ? cnt_q + 3'h1 :
		(pop & ~push) ? cnt_q - 3'h1 : cnt_q;

	always_ff @(posedge CLK_I) begin
		if (push) begin
			mem[wr_q] <= s3_q[32:0];
		end
	end

	// buffer pointers and fill level
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= 3'h0;
		end else begin
			wr_q <= push ? wr_q + 2'h1 : wr_q;
			rd_q <= pop ? rd_q + 2'h1 : rd_q;
			cnt_q <= cnt_d;
		end
	end

	// ==========================================================
	// internal side: data out, primitives discarded
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rxd_q <= 32'h0000_0000;
			rxv_q <= 1'b0;
		end else begin
			rxd_q <= tick ? rd_w[31:0] : rxd_q;
			rxv_q <= tick & ~prim_match(rd_w[32], rd_w[31:0]);
		end
	end

	// overrun and underrun pulses
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ovr_q <= 1'b0;
			und_q <= 1'b0;
		end else begin
			ovr_q <= rx_edge & ~room & ~rx_prim;
			und_q <= tick & empty;
		end
	end

	assign RX_DAT_O = rxd_q;
	assign RX_VALID_O = rxv_q;
	assign RX_OVERRUN_O = ovr_q;
	assign RX_UNDERRUN_O = und_q;
endmodule : asm_phy_dev

//--- hw/asm_pkg.sv
// shared constants, types and helpers for the align and skew logic
package asm_pkg;

	// ==========================================================
	// link modes and rates
	typedef enum logic [1:0] {MODE_OOB, MODE_SPEED, MODE_LINK} asm_mode_e;
	localparam logic [1:0] RATE_1G5 = 2'h0;
	localparam logic [1:0] RATE_3G0 = 2'h1;
	localparam logic [1:0] RATE_6G0 = 2'h2;

	// ==========================================================
	// slot timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] LINK_DIV_M1 = DIV_W'(LINK_DIV - 1);
	localparam logic [DIV_W-1:0] LINK_HALF = DIV_W'(LINK_DIV / 2);

	// ==========================================================
	// skew insertion windows: primitives per window of dwords
	localparam int SKW_WIN_1G5 = 64;
	localparam int SKW_NUM_1G5 = 1;
	localparam int SKW_WIN_3G0 = 128;
	localparam int SKW_NUM_3G0 = 2;
	localparam int SKW_WIN_6G0 = 256;
	localparam int SKW_NUM_6G0 = 4;
	localparam logic [7:0] SKW_LIM_1G5 = 8'(SKW_WIN_1G5 / SKW_NUM_1G5 - 1);
	localparam logic [7:0] SKW_LIM_3G0 = 8'(SKW_WIN_3G0 / SKW_NUM_3G0 - 1);
	localparam logic [7:0] SKW_LIM_6G0 = 8'(SKW_WIN_6G0 / SKW_NUM_6G0 - 1);
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] CNT_SAT = 8'hFF;

	// ==========================================================
	// notify spacing, bridge pairs, elasticity buffer
	localparam logic [1:0] NTF_RUN_MAX = 2'h3;
	localparam logic [1:0] NTF_GAP_MIN = 2'h3;
	localparam logic [1:0] ROT_RST = 2'h0;
	localparam logic [7:0] BRG_RUN_MAX = 8'hFE;
	localparam int EB_AW = 2;
	localparam logic [2:0] EB_DEPTH = 3'h4;

	// ==========================================================
	// primitive dwords, values arbitrary
	localparam logic [3:0][31:0] ALIGN_DW = {32'hA3A3_0F03, 32'hA2A2_0F02,
		32'hA1A1_0F01, 32'hA0A0_0F00};
	localparam logic [31:0] NOTIFY_DW = 32'hB0B0_0F10;

	// full four-character compare
	function automatic logic prim_match(input logic k, input logic [31:0] dw);
		prim_match = k && (dw == ALIGN_DW[0] || dw == ALIGN_DW[1] ||
			dw == ALIGN_DW[2] || dw == ALIGN_DW[3] || dw == NOTIFY_DW);
	endfunction : prim_match

	function automatic logic [7:0] skw_limit(input logic [1:0] rate);
		case (rate)
			RATE_3G0: skw_limit = SKW_LIM_3G0;
			RATE_6G0: skw_limit = SKW_LIM_6G0;
			default: skw_limit = SKW_LIM_1G5;
		endcase
	endfunction : skw_limit

endpackage : asm_pkg

//--- hw/asm_link_if.sv
// serial link between the device phy and its partner phy
`timescale 1ns/1ns
interface asm_link_if;
	logic dev_clk;
	logic dev_k;
	logic [31:0] dev_dw;
	logic ptr_clk;
	logic ptr_k;
	logic [31:0] ptr_dw;
	modport dev (output dev_clk, dev_k, dev_dw, input ptr_clk, ptr_k, ptr_dw);
	modport ptr (input dev_clk, dev_k, dev_dw, output ptr_clk, ptr_k, ptr_dw);
endinterface : asm_link_if

//--- hw/asm_prim_sel.sv
// picks the primitive for a slot: align version, rotation, notify spacing
`timescale 1ns/1ns
module asm_prim_sel (
	input logic clk_i,
	input logic srst_i,
	input asm_pkg::asm_mode_e mode_i,
	input logic notify_en_i,
	input logic notify_rot_i,
	input logic slot_i,
	input logic prim_i,
	output logic [31:0] prim_o,
	output logic ntf_o
);
	import asm_pkg::*;

	logic [1:0] rot_q, rot_d, run_q, run_d, gap_q, gap_d;
	logic sn_q, sn_d, in_link, ntf_ok, rot_step;

	assign in_link = (mode_i == MODE_LINK);
	assign ntf_ok = notify_en_i && in_link && ((run_q != 2'h0) ?
		(run_q < NTF_RUN_MAX) : (gap_q == NTF_GAP_MIN));
	assign ntf_o = ntf_ok;
	assign prim_o = (mode_i == MODE_OOB) ? ALIGN_DW[0] :
		(mode_i == MODE_SPEED) ? ALIGN_DW[{1'b0, sn_q}] :
		ntf_ok ? NOTIFY_DW : ALIGN_DW[rot_q];
	assign rot_step = slot_i && prim_i && (!ntf_ok || notify_rot_i);
	// rotation held at version 0 until the reset sequence is over
	assign rot_d = !in_link ? ROT_RST : rot_step ? rot_q + 2'h1 : rot_q;
	assign sn_d = (mode_i == MODE_SPEED) ? (slot_i ^ sn_q) : 1'b0;

	always_comb begin
		run_d = run_q;
		gap_d = gap_q;
		if (slot_i && prim_i && ntf_ok) begin
			run_d = run_q + 2'h1;
			gap_d = 2'h0;
		end else if (slot_i) begin
			run_d = 2'h0;
			gap_d = (gap_q == NTF_GAP_MIN) ? gap_q : gap_q + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rot_q <= ROT_RST;
			run_q <= 2'h0;
			gap_q <= NTF_GAP_MIN;
			sn_q <= 1'b0;
		end else begin
			rot_q <= rot_d;
			run_q <= run_d;
			gap_q <= gap_d;
			sn_q <= sn_d;
		end
	end
endmodule : asm_prim_sel

//--- hw/asm_phy_ptr.sv
// partner phy end: originating transmitter and primitive-stripping receiver
`timescale 1ns/1ns
module asm_phy_ptr (
	input logic CLK_I,
	input logic SRST_I,
	input asm_pkg::asm_mode_e MODE_I,
	input logic [1:0] RATE_I,
	input logic NOTIFY_EN_I,
	input logic NOTIFY_ROT_I,
	input logic [31:0] TX_DAT_I,
	input logic TX_VALID_I,
	output logic TX_READY_O,
	output logic [31:0] RX_DAT_O,
	output logic RX_VALID_O,
	asm_link_if.ptr LINK
);
	import asm_pkg::*;

	// ==========================================================
	// slot timing and transmit
	logic [DIV_W-1:0] div_q, div_d;
	logic clk_q, tick, need, ntf;
	logic [7:0] skw_q, skw_d;
	logic [31:0] prim_dw;
	logic [32:0] tx_q;

	assign tick = (div_q == LINK_DIV_M1);
	assign div_d = tick ? '0 : div_q + 3'h1;
	assign need = (MODE_I != MODE_LINK) | ~TX_VALID_I |
		(skw_q >= skw_limit(RATE_I));
	assign TX_READY_O = tick & ~need;
	assign skw_d = need ? CNT_RST :
		(skw_q == CNT_SAT) ? skw_q : skw_q + 8'h01;

	asm_prim_sel u_sel (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.mode_i(MODE_I),
		.notify_en_i(NOTIFY_EN_I),
		.notify_rot_i(NOTIFY_ROT_I),
		.slot_i(tick),
		.prim_i(need),
		.prim_o(prim_dw),
		.ntf_o(ntf)
	);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			div_q <= '0;
			clk_q <= 1'b0;
			skw_q <= CNT_RST;
			tx_q <= {1'b1, ALIGN_DW[0]};
		end else begin
			div_q <= div_d;
			clk_q <= (div_d >= LINK_HALF);
			skw_q <= tick ? skw_d : skw_q;
			tx_q <= !tick ? tx_q : need ? {1'b1, prim_dw} : {1'b0, TX_DAT_I};
		end
	end

	assign LINK.ptr_clk = clk_q;
	assign LINK.ptr_k = tx_q[32];
	assign LINK.ptr_dw = tx_q[31:0];

	// ==========================================================
	// receive: sample, find edges, drop every primitive
	logic [33:0] s1_q, s2_q, s3_q;
	logic lvl_q, agree, rx_edge, rxv_q;
	logic [31:0] rxd_q;

	assign agree = (s2_q == s3_q);
	assign rx_edge = agree & s3_q[33] & ~lvl_q;

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= 1'b0;
			rxd_q <= 32'h0000_0000;
			rxv_q <= 1'b0;
		end else begin
			s1_q <= {LINK.dev_clk, LINK.dev_k, LINK.dev_dw};
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= agree ? s3_q[33] : lvl_q;
			rxd_q <= rx_edge ? s3_q[31:0] : rxd_q;
			rxv_q <= rx_edge & ~prim_match(s3_q[32], s3_q[31:0]);
		end
	end

	assign RX_DAT_O = rxd_q;
	assign RX_VALID_O = rxv_q;
endmodule : asm_phy_ptr

//--- bench/asm_link_assertions.sv
// link checker for the align, notify and skew behaviour of the device end
`timescale 1ns/1ns
module asm_link_assertions
	import asm_pkg::*;
(
	input logic CLK_I,
	input logic SRST_I,
	input asm_pkg::asm_mode_e MODE_I,
	input logic ORIG_I,
	input logic BRIDGE_I,
	input logic NOTIFY_ROT_I,
	input logic dev_clk,
	input logic dev_k,
	input logic [31:0] dev_dw,
	input logic ptr_k,
	input logic [31:0] ptr_dw
);
	// ==========================================================
	// slot tracking
	logic clk_q;
	logic slot;
	logic ntf;
	logic [1:0] rot_q;
	logic [1:0] run_q;
	logic [1:0] gap_q;
	logic [7:0] dat_q;
	assign slot = clk_q && !dev_clk;
	assign ntf = dev_k && dev_dw == NOTIFY_DW;
	always_ff @(posedge CLK_I) begin
		clk_q <= dev_clk;
	end
	always_ff @(posedge CLK_I) begin
		if (SRST_I || MODE_I != MODE_LINK) begin
			rot_q <= 2'h0;
		end else if (slot && dev_k && (!ntf || NOTIFY_ROT_I)) begin
			rot_q <= rot_q + 2'h1;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			run_q <= 2'h0;
			gap_q <= 2'h3;
		end else if (slot) begin
			run_q <= ntf ? run_q + 2'h1 : 2'h0;
			gap_q <= ntf ? 2'h0 : (gap_q == 2'h3 ? gap_q : gap_q + 2'h1);
		end
	end
	always_ff @(posedge CLK_I) begin
		if (SRST_I || (slot && dev_k)) begin
			dat_q <= 8'h00;
		end else if (slot) begin
			dat_q <= dat_q + 8'h01;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	sequence s_shape;
		!dev_clk [*4] ##1 dev_clk [*4] ##1 !dev_clk;
	endsequence
	sequence s_pair;
		slot && BRIDGE_I && dev_k && !$past(dev_k, 8);
	endsequence
	chk_slot_shape: assert property ($fell(dev_clk) |-> s_shape)
		else $error("link clock slot shape wrong");
	chk_dword_stands: assert property ($fell(dev_clk) |=> $stable(dev_dw) [*7])
		else $error("link dword changed inside slot");
	chk_oob_align: assert property (slot && MODE_I == MODE_OOB |->
		dev_k && dev_dw == ALIGN_DW[0]) else $error("oob slot not align 0");
	chk_speed_align: assert property (slot && MODE_I == MODE_SPEED |->
		dev_k && (dev_dw == ALIGN_DW[0] || dev_dw == ALIGN_DW[1]) && ptr_k &&
		(ptr_dw == ALIGN_DW[0] || ptr_dw == ALIGN_DW[1]))
		else $error("speed slot not align 0 or 1");
	chk_align_rotation: assert property (slot && MODE_I == MODE_LINK &&
		dev_k && !ntf |-> dev_dw == ALIGN_DW[rot_q])
		else $error("align version out of rotation");
	chk_notify_spacing: assert property (slot && ntf |-> run_q < 2'h3 &&
		(run_q != 2'h0 || gap_q == 2'h3)) else $error("notify spacing broken");
	chk_skew_window: assert property (slot && !dev_k && ORIG_I &&
		!BRIDGE_I |-> dat_q < 8'h3F) else $error("skew primitive missing");
	chk_bridge_run: assert property (slot && !dev_k && BRIDGE_I |->
		dat_q < 8'hFE) else $error("bridge run too long");
	chk_bridge_pair: assert property (s_pair |-> ##8 dev_k)
		else $error("bridge align not paired");
endmodule : asm_link_assertions

//--- bench/align_skew_manager_test.sv
// bench joining device and partner phy ends over the link
`timescale 1ns/1ns
module align_skew_manager_test;
	import asm_pkg::*;
	logic clk = 1'b0;
	logic clk_p = 1'b0;
	int half_p = 10;
	logic srst = 1'b1;
	asm_mode_e mode = MODE_OOB;
	logic [1:0] rate = RATE_1G5;
	logic orig = 1'b1;
	logic bridge = 1'b0;
	logic ntf_en = 1'b1;
	logic ntf_rot = 1'b0;
	logic [31:0] d_dat = 32'h0000_0000;
	logic d_val = 1'b0;
	logic [31:0] p_dat = 32'h0000_0000;
	logic p_val = 1'b0;
	logic d_rdy, d_rxv, d_ovr, d_und, p_rdy, p_rxv;
	logic [31:0] d_rx, p_rx;
	int fail_count = 0;
	int total_checks = 0;
	int n_ovr = 0;
	int n_und = 0;
	int n_ntf = 0;
	logic [31:0] d_q[$];
	logic [31:0] p_q[$];
	asm_link_if link ();
	always #10 clk = ~clk;
	always #(half_p) clk_p = ~clk_p;
	asm_phy_dev asm_phy_dev_i (.CLK_I(clk), .SRST_I(srst), .MODE_I(mode),
		.RATE_I(rate), .ORIG_I(orig), .BRIDGE_I(bridge), .NOTIFY_EN_I(ntf_en),
		.NOTIFY_ROT_I(ntf_rot), .TX_DAT_I(d_dat), .TX_VALID_I(d_val),
		.TX_READY_O(d_rdy), .RX_DAT_O(d_rx), .RX_VALID_O(d_rxv),
		.RX_OVERRUN_O(d_ovr), .RX_UNDERRUN_O(d_und), .LINK(link.dev));
	asm_phy_ptr asm_phy_ptr_i (.CLK_I(clk_p), .SRST_I(srst), .MODE_I(mode),
		.RATE_I(rate), .NOTIFY_EN_I(ntf_en), .NOTIFY_ROT_I(ntf_rot),
		.TX_DAT_I(p_dat), .TX_VALID_I(p_val), .TX_READY_O(p_rdy),
		.RX_DAT_O(p_rx), .RX_VALID_O(p_rxv), .LINK(link.ptr));
	asm_link_assertions asm_link_assertions_i (.CLK_I(clk), .SRST_I(srst),
		.MODE_I(mode), .ORIG_I(orig), .BRIDGE_I(bridge),
		.NOTIFY_ROT_I(ntf_rot), .dev_clk(link.dev_clk), .dev_k(link.dev_k),
		.dev_dw(link.dev_dw), .ptr_k(link.ptr_k), .ptr_dw(link.ptr_dw));
	// sample registered outputs mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (d_rxv === 1'b1) d_q.push_back(d_rx);
		n_ovr += (d_ovr === 1'b1);
		n_und += (d_und === 1'b1);
		n_ntf += (link.dev_k === 1'b1 && link.dev_dw === NOTIFY_DW);
	end
	always @(negedge clk_p) if (p_rxv === 1'b1) p_q.push_back(p_rx);
	// ==========================================================
	// shared tasks
	task automatic end_of_test();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic bound(input int w, input int lim);
		if (w >= lim) begin
			fail_count++;
			end_of_test();
		end
	endtask : bound
	task automatic slots(input int n);
		repeat (8 * n) @(posedge clk);
		#1;
	endtask : slots
	task automatic clr();
		d_q.delete();
		p_q.delete();
		n_ovr = 0;
		n_und = 0;
		n_ntf = 0;
	endtask : clr
	// change mode and notify rotation only while the link clock is high, off a slot start
	task automatic mid_slot();
		int w;
		w = 0;
		do begin
			@(posedge clk);
			#1;
			w++;
		end while (link.dev_clk !== 1'b1 && w < 20);
		bound(w, 20);
	endtask : mid_slot
	task automatic set_mode(input asm_mode_e m);
		mid_slot();
		mode = m;
	endtask : set_mode
	task automatic send(input bit ptr, input int n, input logic [31:0] base);
		int w;
		for (int i = 0; i < n; i++) begin
			if (ptr) p_dat = base + 32'(i);
			else d_dat = base + 32'(i);
			if (ptr) p_val = 1'b1;
			else d_val = 1'b1;
			w = 0;
			do begin
				if (ptr) @(negedge clk_p);
				else @(negedge clk);
				w++;
			end while ((ptr ? p_rdy : d_rdy) !== 1'b1 && w < 200);
			bound(w, 200);
			if (ptr) @(posedge clk_p);
			else @(posedge clk);
			#1;
		end
		if (ptr) p_val = 1'b0;
		else d_val = 1'b0;
	endtask : send
	// ==========================================================
	// scenarios
	task automatic t_reset();
		repeat (20) @(posedge clk);
		#1;
		check("rst_k", 32'(link.dev_k), 32'h1);
		check("rst_dw", link.dev_dw, ALIGN_DW[0]);
		srst = 1'b0;
		slots(6);
		check("oob_ntf", n_ntf, 0);
	endtask : t_reset
	task automatic t_speed();
		int a1, rdy;
		a1 = 0;
		rdy = 0;
		set_mode(MODE_SPEED);
		d_val = 1'b1;
		repeat (64) begin
			@(posedge clk);
			#1;
			a1 += (link.dev_dw === ALIGN_DW[1]);
			rdy += (d_rdy === 1'b1);
		end
		d_val = 1'b0;
		check("spd_a1", 32'(a1 > 0), 32'h1);
		check("spd_rdy", rdy, 0);
		check("spd_ntf", n_ntf, 0);
	endtask : t_speed
	task automatic t_link();
		set_mode(MODE_LINK);
		fork
			send(1'b0, 40, 32'h1000_0000);
			send(1'b1, 40, 32'h2000_0000);
		join
		slots(6);
		check("lnk_pn", p_q.size(), 40);
		check("lnk_dn", d_q.size(), 40);
		check("lnk_ovr", n_ovr, 0);
		for (int i = 0; i < 40; i++) begin
			check("lnk_pd", p_q[i], 32'h1000_0000 + 32'(i));
			check("lnk_dd", d_q[i], 32'h2000_0000 + 32'(i));
		end
	endtask : t_link
	task automatic t_notify();
		for (int r = 0; r < 2; r++) begin
			mid_slot();
			ntf_rot = r[0];
			clr();
			slots(24);
			check("ntf_seen", 32'(n_ntf > 0), 32'h1);
		end
		ntf_en = 1'b0;
	endtask : t_notify
	task automatic t_skew();
		for (int r = 0; r < 3; r++) begin
			rate = 2'(r);
			clr();
			send(1'b0, 140, 32'h3000_0000);
			slots(6);
			check("skw_n", p_q.size(), 140);
		end
	endtask : t_skew
	task automatic t_bridge();
		bridge = 1'b1;
		clr();
		send(1'b0, 300, 32'h5000_0000);
		slots(6);
		check("brg_n", p_q.size(), 300);
		bridge = 1'b0;
		orig = 1'b0;
		clr();
		send(1'b0, 100, 32'h6000_0000);
		slots(6);
		check("fwd_n", p_q.size(), 100);
		orig = 1'b1;
	endtask : t_bridge
	task automatic t_ovr_und();
		half_p = 9;
		clr();
		send(1'b1, 200, 32'h4000_0000);
		slots(8);
		check("ovr_seen", 32'(n_ovr > 0), 32'h1);
		check("ovr_sum", d_q.size() + n_ovr, 200);
		half_p = 12;
		clr();
		send(1'b1, 100, 32'h7000_0000);
		slots(8);
		check("und_seen", 32'(n_und > 0), 32'h1);
		check("und_n", d_q.size(), 100);
	endtask : t_ovr_und
	initial begin
		t_reset();
		t_speed();
		t_link();
		t_notify();
		t_skew();
		t_bridge();
		t_ovr_und();
		end_of_test();
	end
endmodule : align_skew_manager_test
